/* File: rtl/ase_axis_status.v */
// Axis status, encoder counters, deviation supervision and drive selection
//
// Functional notes
// - Read-only load measurement, 0 to 1023
// - Extended error: 1 stall, 2 deviation
// - Extended errors clear on read or motion
// - Driver bits 0-2: stall, overheat, warning
// - Bits 3-4: coil short to ground
// - Bits 5-6: open load per coil
// - Bit 7: no step for 2^20 cycles
// - Signed 32-bit writable built-in encoder count
// - Clear-on-null zeroes count, then self-clears
// - Stop on built-in deviation over limit
// - Stop on external deviation over limit
// - Standby after delay in 10 ms units
// - Read-only rotor angle within one turn
// - Signed 32-bit writable external AB count
// - Shaft reversal inverts direction
// - Mode 0 ramp, mode 1 step/dir pins
// - Velocity unit select, default 1
`timescale 1ns/1ps
`include "ase_defs.vh"

module ase_axis_status #(
    parameter STANDSTILL_CYCLES = `ASE_STANDSTILL_CYC,
    parameter STANDBY_UNIT_CYCLES = `ASE_STANDBY_UNIT_CYC
) (
    input wire clock,
    input wire rst_n,
    // Parameter access port
    input wire [7:0] param_num,
    input wire param_wr,
    input wire param_rd,
    input wire [31:0] param_wdata,
    output reg [31:0] param_rdata_q,
    output reg param_rvalid_q,
    // Motion core side, same clock
    input wire motion_cmd,
    input wire [31:0] actual_pos,
    input wire ramp_step,
    input wire ramp_dir,
    // Driver status, same clock
    input wire [9:0] load_value,
    input wire stall_in,
    input wire ot_shutdown_in,
    input wire ot_warn_in,
    input wire short_a_in,
    input wire short_b_in,
    input wire open_a_in,
    input wire open_b_in,
    // Built-in encoder, same clock
    input wire enc_step,
    input wire enc_dir,
    input wire enc_null,
    input wire [9:0] enc_angle,
    // Pins from outside
    input wire ext_enc_a,
    input wire ext_enc_b,
    input wire sd_step_pin,
    input wire sd_dir_pin,
    // Drive outputs
    output reg step_out_q,
    output reg dir_out_q,
    output reg stop_req_q,
    output reg standby_q,
    output reg unit_pps_q
);

    //--------------------------------------------------------------
    // Pin synchronisers
    //--------------------------------------------------------------
    reg [3:0] pin_meta_q;
    reg [3:0] pin_sync_q;
    wire qa = pin_sync_q[0];
    wire qb = pin_sync_q[1];
    wire sd_step = pin_sync_q[2];
    wire sd_dir = pin_sync_q[3];

    // Two stages; only the second stage feeds logic
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q <= 4'h0;
            pin_sync_q <= 4'h0;
        end else begin
            pin_meta_q <= {sd_dir_pin, sd_step_pin, ext_enc_b, ext_enc_a};
            pin_sync_q <= pin_meta_q;
        end
    end

    //--------------------------------------------------------------
    // Configuration registers
    //--------------------------------------------------------------
    reg [31:0] enc_count_q;
    reg [31:0] ext_count_q;
    reg [31:0] ext_cpr_q;
    reg [31:0] int_limit_q;
    reg [31:0] ext_limit_q;
    reg [15:0] standby_delay_q;
    reg zero_clear_q;
    reg reverse_q;
    reg source_q;
    reg [7:0] xerr_q;
    reg [7:0] derr_q;
    reg [9:0] load_q;
    reg [9:0] angle_q;

    // Strobe qualified by one parameter number; shared by all side-effect paths
    function num_hit;
        input strobe;
        input [7:0] num;
        input [7:0] code;
        begin
            num_hit = strobe && (num == code);
        end
    endfunction

    wire wr_hit_enc = num_hit(param_wr, param_num, `ASE_PN_BUILTIN_ENC_COUNT);
    wire wr_hit_ext = num_hit(param_wr, param_num, `ASE_PN_EXT_ENC_COUNT);
    wire wr_hit_zero = num_hit(param_wr, param_num, `ASE_PN_ENC_ZERO_CLEAR);
    wire rd_xerr = num_hit(param_rd, param_num, `ASE_PN_EXTENDED_ERROR);

    // Host writable settings; read-only numbers fall through untouched
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ext_cpr_q <= `ASE_RST_WORD;
            int_limit_q <= `ASE_RST_WORD;
            ext_limit_q <= `ASE_RST_WORD;
            standby_delay_q <= `ASE_RST_STANDBY_DELAY;
            reverse_q <= 1'b0;
            source_q <= 1'b0;
            unit_pps_q <= `ASE_RST_VELOCITY_UNIT;
        end else if (param_wr) begin
            case (param_num)
                `ASE_PN_EXT_ENC_CPR: ext_cpr_q <= {1'b0, param_wdata[30:0]};
                `ASE_PN_BUILTIN_DEV_LIMIT: int_limit_q <= {1'b0, param_wdata[30:0]};
                `ASE_PN_EXT_DEV_LIMIT: ext_limit_q <= {1'b0, param_wdata[30:0]};
                `ASE_PN_STANDBY_DELAY: standby_delay_q <= param_wdata[15:0];
                `ASE_PN_SHAFT_REVERSE: reverse_q <= param_wdata[0];
                `ASE_PN_DRIVE_SOURCE: source_q <= param_wdata[0];
                `ASE_PN_VELOCITY_UNIT: unit_pps_q <= param_wdata[0];
                default: ; // Load, errors, angle stay measured
            endcase
        end
    end

    //--------------------------------------------------------------
    // Built-in encoder counter
    //--------------------------------------------------------------
    wire null_clear = zero_clear_q && enc_null;

    // Host write beats counting; null clear beats counting too
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            enc_count_q <= `ASE_RST_WORD;
            zero_clear_q <= 1'b0;
        end else begin
            if (wr_hit_enc) begin
                enc_count_q <= param_wdata;
            end else if (null_clear) begin
                enc_count_q <= `ASE_RST_WORD;
            end else if (enc_step) begin
                enc_count_q <= enc_dir ? enc_count_q - 32'h0000_0001
                                       : enc_count_q + 32'h0000_0001;
            end
            if (wr_hit_zero) begin
                zero_clear_q <= param_wdata[0];
            end else if (null_clear) begin
                zero_clear_q <= 1'b0; // Self-return after clearing
            end
        end
    end

    //--------------------------------------------------------------
    // External AB quadrature counter
    //--------------------------------------------------------------
    reg qa_prev_q;
    reg qb_prev_q;
    // One edge of either channel is one count; a double jump is dropped
    wire q_move = qa ^ qa_prev_q ^ qb ^ qb_prev_q;
    wire q_up = qa_prev_q ^ qb;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            qa_prev_q <= 1'b0;
            qb_prev_q <= 1'b0;
            ext_count_q <= `ASE_RST_WORD;
        end else begin
            qa_prev_q <= qa;
            qb_prev_q <= qb;
            if (wr_hit_ext) begin
                ext_count_q <= param_wdata;
            end else if (q_move) begin
                ext_count_q <= q_up ? ext_count_q + 32'h0000_0001
                                    : ext_count_q - 32'h0000_0001;
            end
        end
    end

    //--------------------------------------------------------------
    // Deviation supervision
    //--------------------------------------------------------------
    wire [32:0] int_diff = {actual_pos[31], actual_pos} - {enc_count_q[31], enc_count_q};
    wire [32:0] ext_diff = {actual_pos[31], actual_pos} - {ext_count_q[31], ext_count_q};

    // Magnitude of a gap; 33 bits so the widest gap cannot overflow
    function [32:0] mag33;
        input [32:0] diff;
        begin
            mag33 = diff[32] ? (33'h0_0000_0000 - diff) : diff;
        end
    endfunction

    wire [32:0] int_mag = mag33(int_diff);
    wire [32:0] ext_mag = mag33(ext_diff);
    wire int_over = (int_limit_q != 32'h0000_0000) && (int_mag > {1'b0, int_limit_q});
    wire ext_over = (ext_limit_q != 32'h0000_0000) && (ext_mag > {1'b0, ext_limit_q});
    wire dev_over = int_over || ext_over;
    reg dev_over_q;

    // Stop request is a pulse on entry into violation, so one stop per event
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dev_over_q <= 1'b0;
            stop_req_q <= 1'b0;
        end else begin
            dev_over_q <= dev_over;
            stop_req_q <= dev_over && !dev_over_q;
        end
    end

    //--------------------------------------------------------------
    // Extended error flags
    //--------------------------------------------------------------
    reg stall_prev_q;
    wire stall_rise = stall_in && !stall_prev_q;
    wire dev_rise = dev_over && !dev_over_q;

    // A new event in the clearing cycle survives: set wins
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stall_prev_q <= 1'b0;
            xerr_q <= 8'h00;
        end else begin
            stall_prev_q <= stall_in;
            xerr_q <= (rd_xerr || motion_cmd) ? 8'h00 : xerr_q;
            if (stall_rise) begin
                xerr_q[`ASE_XERR_STALL] <= 1'b1;
            end
            if (dev_rise) begin
                xerr_q[`ASE_XERR_DEVIATION] <= 1'b1;
            end
        end
    end

    //--------------------------------------------------------------
    // Drive source, reversal and step output
    //--------------------------------------------------------------
    reg sd_step_prev_q;
    wire sd_pulse = sd_step && !sd_step_prev_q;
    wire sel_step = source_q ? sd_pulse : ramp_step;
    wire sel_dir = source_q ? sd_dir : ramp_dir;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sd_step_prev_q <= 1'b0;
            step_out_q <= 1'b0;
            dir_out_q <= 1'b0;
        end else begin
            sd_step_prev_q <= sd_step;
            step_out_q <= sel_step;
            dir_out_q <= sel_dir ^ reverse_q;
        end
    end

    //--------------------------------------------------------------
    // Standstill detection and driver flags
    //--------------------------------------------------------------
    reg [31:0] still_cnt_q;
    wire still_now = (still_cnt_q >= STANDSTILL_CYCLES);

    // Counter saturates so a long stop cannot wrap back to moving
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            still_cnt_q <= 32'h0000_0000;
        end else if (step_out_q) begin
            still_cnt_q <= 32'h0000_0000;
        end else if (!still_now) begin
            still_cnt_q <= still_cnt_q + 32'h0000_0001;
        end
    end

    // Driver byte mirrors live driver status plus own standstill
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            derr_q <= 8'h00;
            load_q <= 10'h000;
            angle_q <= 10'h000;
        end else begin
            derr_q[`ASE_DERR_STALL] <= stall_in;
            derr_q[`ASE_DERR_OT_SHUTDOWN] <= ot_shutdown_in;
            derr_q[`ASE_DERR_OT_WARN] <= ot_warn_in;
            derr_q[`ASE_DERR_SHORT_A] <= short_a_in;
            derr_q[`ASE_DERR_SHORT_B] <= short_b_in;
            derr_q[`ASE_DERR_OPEN_A] <= open_a_in;
            derr_q[`ASE_DERR_OPEN_B] <= open_b_in;
            derr_q[`ASE_DERR_STANDSTILL] <= still_now;
            load_q <= load_value;
            angle_q <= enc_angle;
        end
    end

    //--------------------------------------------------------------
    // Standby current delay
    //--------------------------------------------------------------
    reg [31:0] tick_cnt_q;
    reg [15:0] unit_cnt_q;
    wire tick_end = (tick_cnt_q == STANDBY_UNIT_CYCLES - 1);

    // Delay restarts whenever the motor moves again
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= 32'h0000_0000;
            unit_cnt_q <= 16'h0000;
            standby_q <= 1'b0;
        end else if (!still_now) begin
            tick_cnt_q <= 32'h0000_0000;
            unit_cnt_q <= 16'h0000;
            standby_q <= 1'b0;
        end else if (unit_cnt_q >= standby_delay_q) begin
            standby_q <= 1'b1; // Zero delay drops at once
        end else begin
            tick_cnt_q <= tick_end ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
            if (tick_end) begin
                unit_cnt_q <= unit_cnt_q + 16'h0001;
            end
        end
    end

    //--------------------------------------------------------------
    // Parameter readback
    //--------------------------------------------------------------
    reg [31:0] rd_mux;

    // Unknown numbers read as zero
    always @* begin
        case (param_num)
            `ASE_PN_LOAD_MEASURE: rd_mux = {22'h00_0000, load_q};
            `ASE_PN_EXTENDED_ERROR: rd_mux = {24'h00_0000, xerr_q};
            `ASE_PN_DRIVER_ERROR: rd_mux = {24'h00_0000, derr_q};
            `ASE_PN_BUILTIN_ENC_COUNT: rd_mux = enc_count_q;
            `ASE_PN_ENC_ZERO_CLEAR: rd_mux = {31'h0000_0000, zero_clear_q};
            `ASE_PN_BUILTIN_DEV_LIMIT: rd_mux = int_limit_q;
            `ASE_PN_STANDBY_DELAY: rd_mux = {16'h0000, standby_delay_q};
            `ASE_PN_ROTOR_ANGLE: rd_mux = {22'h00_0000, angle_q};
            `ASE_PN_EXT_ENC_COUNT: rd_mux = ext_count_q;
            `ASE_PN_EXT_ENC_CPR: rd_mux = ext_cpr_q;
            `ASE_PN_EXT_DEV_LIMIT: rd_mux = ext_limit_q;
            `ASE_PN_SHAFT_REVERSE: rd_mux = {31'h0000_0000, reverse_q};
            `ASE_PN_DRIVE_SOURCE: rd_mux = {31'h0000_0000, source_q};
            `ASE_PN_VELOCITY_UNIT: rd_mux = {31'h0000_0000, unit_pps_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data captured with the value before any read-clear
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            param_rdata_q <= 32'h0000_0000;
            param_rvalid_q <= 1'b0;
        end else begin
            param_rvalid_q <= param_rd;
            if (param_rd) begin
                param_rdata_q <= rd_mux;
            end
        end
    end

endmodule

/* File: rtl/ase_defs.vh */
// Parameter numbers, field positions, reset values and timing for the axis status block
`ifndef ASE_DEFS_VH
`define ASE_DEFS_VH

// Parameter numbers
`define ASE_PN_LOAD_MEASURE 8'hce
`define ASE_PN_EXTENDED_ERROR 8'hcf
`define ASE_PN_DRIVER_ERROR 8'hd0
`define ASE_PN_BUILTIN_ENC_COUNT 8'hd1
`define ASE_PN_ENC_ZERO_CLEAR 8'hd2
`define ASE_PN_BUILTIN_DEV_LIMIT 8'hd4
`define ASE_PN_STANDBY_DELAY 8'hd6
`define ASE_PN_ROTOR_ANGLE 8'hd7
`define ASE_PN_EXT_ENC_COUNT 8'hd8
`define ASE_PN_EXT_ENC_CPR 8'hd9
`define ASE_PN_EXT_DEV_LIMIT 8'hda
`define ASE_PN_SHAFT_REVERSE 8'hfb
`define ASE_PN_DRIVE_SOURCE 8'hfe
`define ASE_PN_VELOCITY_UNIT 8'hff

// Extended error bit positions
`define ASE_XERR_STALL 0
`define ASE_XERR_DEVIATION 1

// Driver error bit positions
`define ASE_DERR_STALL 0
`define ASE_DERR_OT_SHUTDOWN 1
`define ASE_DERR_OT_WARN 2
`define ASE_DERR_SHORT_A 3
`define ASE_DERR_SHORT_B 4
`define ASE_DERR_OPEN_A 5
`define ASE_DERR_OPEN_B 6
`define ASE_DERR_STANDSTILL 7

// Reset values
`define ASE_RST_STANDBY_DELAY 16'h0000
`define ASE_RST_VELOCITY_UNIT 1'b1
`define ASE_RST_WORD 32'h0000_0000

// Timing
`define ASE_CLK_KHZ 125000
`define ASE_STANDBY_UNIT_MS 10
`define ASE_STANDBY_UNIT_CYC (`ASE_STANDBY_UNIT_MS * `ASE_CLK_KHZ)
`define ASE_STANDSTILL_LOG2 20
`define ASE_STANDSTILL_CYC (1 << `ASE_STANDSTILL_LOG2)

`endif

/* File: verification/ase_axis_status_bench.sv */
// Self-checking bench for the axis status block
`timescale 1ns/1ps
module ase_axis_status_bench;
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] param_num = 8'h00;
    logic param_wr = 1'h0, param_rd = 1'h0, motion_cmd = 1'h0, ramp_step = 1'h0, ramp_dir = 1'h0;
    logic [31:0] param_wdata = 32'h0000_0000, actual_pos = 32'h0000_0000;
    logic [9:0] load_value = 10'h3ff, enc_angle = 10'h155;
    logic stall_in = 1'h0, ot_shutdown_in = 1'h0, ot_warn_in = 1'h0, short_a_in = 1'h0;
    logic short_b_in = 1'h0, open_a_in = 1'h0, open_b_in = 1'h0;
    wire [31:0] param_rdata_q;
    wire param_rvalid_q, step_out_q, dir_out_q, stop_req_q, standby_q, unit_pps_q;
    wire enc_step, enc_dir, enc_null, ext_enc_a, ext_enc_b, sd_step_pin, sd_dir_pin;
    int n_errors = 0, checks = 0, hits;
    time t0;
    logic [7:0] ro [4] = '{8'hce, 8'hcf, 8'hd0, 8'hd7};
    logic [7:0] rw [9] = '{8'hd1, 8'hd4, 8'hd6, 8'hd8, 8'hd9, 8'hda, 8'hfb, 8'hfe, 8'hff};
    logic [31:0] rw_exp [9] = '{32'h8000_0000, 32'h7fff_ffff, 32'h0000_01a1, 32'h7fff_ffff,
        32'h7fff_ffff, 32'h7fff_ffff, 32'h0000_0001, 32'h0000_0001, 32'h0000_0000};
    // ----------------------------------------
    // Design, far side and access tasks
    // ----------------------------------------
    ase_axis_status #(.STANDSTILL_CYCLES(64), .STANDBY_UNIT_CYCLES(10)) DUT (.*);
    ase_far_end far (.*);
    initial forever #4 clock = ~clock;
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Strobe drops for a cycle so two accesses never share a time step
    task automatic wr(input logic [7:0] num, input logic [31:0] d);
        param_num = num;
        param_wdata = d;
        param_wr = 1'h1;
        tick();
        param_wr = 1'h0;
        tick();
    endtask
    task automatic rd(input logic [7:0] num, input logic [31:0] exp, input logic [31:0] m = '1);
        param_num = num;
        param_rd = 1'h1;
        tick();
        param_rd = 1'h0;
        check("read answer", {31'h0000_0000, param_rvalid_q}, 32'h0000_0001);
        check($sformatf("param %h", num), param_rdata_q & m, exp);
        tick();
    endtask
    task automatic ramp(input logic dir);
        ramp_dir = dir;
        ramp_step = 1'h1;
        tick();
        ramp_step = 1'h0;
    endtask
    task automatic pulse_motion();
        motion_cmd = 1'h1;
        tick();
        motion_cmd = 1'h0;
        tick();
    endtask
    // Counts stop or step pulses over a window
    task automatic watch(input int n, input bit stop);
        hits = 0;
        repeat (n) begin
            if ((stop ? stop_req_q : step_out_q) === 1'h1) hits++;
            tick();
        end
    endtask
    task automatic settle(input int lo, input int hi);
        repeat (300) if (standby_q !== 1'h1) tick();
        check("standby delay", (($time - t0) / 8) inside {[lo:hi]}, 1);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Hang guard, well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        report_and_stop();
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clock);
        #1;
        rst_n = 1'h1;
        rd(8'hd6, 32'h0000_0000);
        rd(8'hff, 32'h0000_0001);
        check("unit select", unit_pps_q, 1);
        foreach (ro[i]) wr(ro[i], 32'hffff_ffff);
        rd(8'hce, 32'h0000_03ff);
        rd(8'hd7, 32'h0000_0155);
        rd(8'hcf, 32'h0000_0000);
        rd(8'hd0, 32'h0000_0000, 32'h0000_007f);
        load_value = 10'h2a5;
        enc_angle = 10'h0aa;
        tick(2);
        rd(8'hce, 32'h0000_02a5);
        rd(8'hd7, 32'h0000_00aa);
        $display("test reset and read-only done");
        // Limits take a set top bit to prove it is dropped
        foreach (rw[i]) begin
            wr(rw[i], rw_exp[i] | ((rw[i] inside {8'hd4, 8'hda}) ? 32'h8000_0000 : 0));
            rd(rw[i], rw_exp[i]);
        end
        check("unit select", unit_pps_q, 0);
        foreach (rw[i]) wr(rw[i], 32'h0000_0000);
        wr(8'hff, 32'h0000_0001);
        $display("test writable parameters done");
        for (int i = 0; i < 7; i++) begin
            {open_b_in, open_a_in, short_b_in, short_a_in, ot_warn_in, ot_shutdown_in,
                stall_in} = 7'h01 << i;
            tick(2);
            rd(8'hd0, 32'h0000_0001 << i, 32'h0000_007f);
        end
        stall_in = 1'h0;
        pulse_motion();
        rd(8'hcf, 32'h0000_0000);
        stall_in = 1'h1;
        tick(2);
        // Back-to-back reads: the first sees the flag, the second finds it cleared
        param_num = 8'hcf;
        param_rd = 1'h1;
        tick();
        check("stall error", param_rdata_q, 32'h0000_0001);
        tick();
        param_rd = 1'h0;
        check("stall error cleared", param_rdata_q, 32'h0000_0000);
        stall_in = 1'h0;
        tick();
        stall_in = 1'h1;
        tick(2);
        pulse_motion();
        rd(8'hcf, 32'h0000_0000);
        stall_in = 1'h0;
        $display("test error flags done");
        far.enc_move(5, 1'h0, 0);
        far.enc_move(2, 1'h1, 3);
        rd(8'hd1, 32'h0000_0003);
        wr(8'hd2, 32'h0000_0001);
        far.null_pulse();
        rd(8'hd1, 32'h0000_0000);
        rd(8'hd2, 32'h0000_0000);
        far.quad(4, 4);
        rd(8'hd8, 32'h0000_0004);
        $display("test encoders done");
        // Difference equal to the limit must not stop, one more must
        actual_pos = 32'h0000_0064;
        wr(8'hd4, 32'h0000_0064);
        watch(8, 1);
        check("no internal stop", hits, 0);
        wr(8'hd4, 32'h0000_0063);
        watch(8, 1);
        check("internal stop", hits, 1);
        rd(8'hcf, 32'h0000_0002, 32'h0000_0002);
        wr(8'hd4, 32'h0000_0000);
        wr(8'hda, 32'h0000_0060);
        watch(8, 1);
        check("no external stop", hits, 0);
        wr(8'hda, 32'h0000_005f);
        watch(8, 1);
        check("external stop", hits, 1);
        wr(8'hda, 32'h0000_0000);
        actual_pos = 32'h0000_0000;
        $display("test deviation done");
        ramp(1'h1);
        check("ramp step", step_out_q, 1);
        check("direction", dir_out_q, 1);
        wr(8'hfb, 32'h0000_0001);
        ramp(1'h1);
        check("reversed direction", dir_out_q, 0);
        wr(8'hfb, 32'h0000_0000);
        wr(8'hfe, 32'h0000_0001);
        ramp(1'h0);
        watch(6, 0);
        check("ramp ignored", hits, 0);
        far.sd_pulse(1'h1);
        watch(8, 0);
        check("pin step", hits, 1);
        check("pin direction", dir_out_q, 1);
        wr(8'hfe, 32'h0000_0000);
        $display("test step paths done");
        wr(8'hd6, 32'h0000_0003);
        ramp(1'h0);
        t0 = $time;
        tick(30);
        rd(8'hd0, 32'h0000_0000, 32'h0000_0080);
        settle(90, 102);
        rd(8'hd0, 32'h0000_0080, 32'h0000_0080);
        wr(8'hd6, 32'h0000_0000);
        ramp(1'h0);
        t0 = $time;
        tick(4);
        check("standby dropped", standby_q, 0);
        settle(62, 72);
        $display("test standstill and standby done");
        report_and_stop();
    end
endmodule
bind ase_axis_status ase_axis_status_props #(.STANDSTILL_CYCLES(STANDSTILL_CYCLES)) u_props (.*);

/* File: verification/ase_axis_status_properties.sv */
// Port checker for the axis status block
`timescale 1ns/1ps
module ase_axis_status_props #(
    parameter STANDSTILL_CYCLES = 64
) (
    input wire clock,
    input wire rst_n,
    input wire [7:0] param_num,
    input wire param_wr,
    input wire param_rd,
    input wire [31:0] param_wdata,
    input wire [31:0] param_rdata_q,
    input wire param_rvalid_q,
    input wire [9:0] load_value,
    input wire [9:0] enc_angle,
    input wire stall_in,
    input wire ot_shutdown_in,
    input wire ot_warn_in,
    input wire short_a_in,
    input wire short_b_in,
    input wire open_a_in,
    input wire open_b_in,
    input wire step_out_q,
    input wire stop_req_q,
    input wire standby_q,
    input wire unit_pps_q
);
    // ----------------------------------------
    // Helpers and checks
    // ----------------------------------------
    logic [31:0] quiet_q;
    wire rd_ce = param_rd && param_num == 8'hce;
    wire rd_cf = param_rd && param_num == 8'hcf;
    wire rd_d0 = param_rd && param_num == 8'hd0;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Cycles since the last step, saturating so it never wraps back to zero
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            quiet_q <= 32'h0000_0000;
        end else if (step_out_q) begin
            quiet_q <= 32'h0000_0000;
        end else if (quiet_q != 32'hffff_ffff) begin
            quiet_q <= quiet_q + 32'h0000_0001;
        end
    end
    a_read_answer: assert property (param_rd |=> param_rvalid_q)
        else $error("read strobe got no answer");
    a_load_readout: assert property (rd_ce |=>
        param_rdata_q == {22'h00_0000, $past(load_value, 2)})
        else $error("load readout wrong");
    a_angle_readout: assert property (param_rd && param_num == 8'hd7 |=>
        param_rdata_q == {22'h00_0000, $past(enc_angle, 2)})
        else $error("rotor angle readout wrong");
    a_driver_flags: assert property (rd_d0 |=> param_rdata_q[6:0] ==
        $past({open_b_in, open_a_in, short_b_in, short_a_in, ot_warn_in,
        ot_shutdown_in, stall_in}, 2))
        else $error("driver flag readout wrong");
    a_standstill_flag: assert property (rd_d0 && quiet_q > STANDSTILL_CYCLES + 2 |=>
        param_rdata_q[7])
        else $error("standstill flag missing");
    a_xerr_read_clear: assert property (
        rd_cf && $stable(stall_in) && $past(stall_in, 2) == stall_in ##1 rd_cf && $stable(stall_in)
        |=> !param_rdata_q[0])
        else $error("stall error survived a read");
    a_unit_write: assert property (param_wr && param_num == 8'hff |->
        ##2 unit_pps_q == $past(param_wdata[0], 2))
        else $error("velocity unit select not taken");
    a_stop_single: assert property (stop_req_q |=> !stop_req_q)
        else $error("stop request longer than one cycle");
    a_standby_drop: assert property (step_out_q |-> ##2 !standby_q)
        else $error("standby held while stepping");
    // Main scenarios reached
    c_stop: cover property (stop_req_q);
    c_standby: cover property ($rose(standby_q));
    c_standstill: cover property (rd_d0 ##1 param_rdata_q[7]);
endmodule

/* File: verification/ase_far_end.sv */
// Far-side model: built-in encoder, AB encoder and step/dir pins
`timescale 1ns/1ps
module ase_far_end (
    input wire clock,
    output logic enc_step,
    output logic enc_dir,
    output logic enc_null,
    output wire ext_enc_a,
    output wire ext_enc_b,
    output logic sd_step_pin,
    output logic sd_dir_pin
);
    logic [1:0] pos = 2'h0;
    initial {enc_step, enc_dir, enc_null, sd_step_pin, sd_dir_pin} = 5'h00;
    // Gray code, one edge per move, so a synchronised sample never skips a state
    assign ext_enc_a = pos[1];
    assign ext_enc_b = pos[1] ^ pos[0];
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Gap sets the pace: 0 answers promptly, larger values are slow
    task automatic enc_move(input int n, input logic dn, input int gap);
        enc_dir = dn;
        repeat (n) begin
            enc_step = 1'h1;
            tick(1);
            enc_step = 1'h0;
            tick(gap + 1);
        end
    endtask
    task automatic null_pulse();
        enc_null = 1'h1;
        tick(1);
        enc_null = 1'h0;
        tick(1);
    endtask
    // Dwell must cover the pin synchronisers
    task automatic quad(input int n, input int gap);
        repeat (n) begin
            pos = pos + 2'h1;
            tick(gap);
        end
    endtask
    task automatic sd_pulse(input logic dir);
        sd_dir_pin = dir;
        tick(3);
        sd_step_pin = 1'h1;
        tick(2);
        sd_step_pin = 1'h0;
    endtask
endmodule
